// ### rtl/lac_pkg.sv
// Purpose: constants and types of the load adaptive coil current block
// Assumes: 16-bit register port, 4-bit word address
package lac_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int PWR_W = 11;
   localparam int CUR_W = 8;
   // word offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_LEARN_CFG = 4'h1;
   localparam logic [3:0] OFS_RESULT_LOW = 4'h2;
   localparam logic [3:0] OFS_RESULT_HIGH = 4'h3;
   localparam logic [3:0] OFS_LIMITS = 4'h4;
   localparam logic [3:0] OFS_BAND = 4'h5;
   localparam logic [3:0] OFS_STATUS = 4'h6;
   localparam logic [3:0] OFS_LOAD = 4'h7;
   // control and status bits
   localparam int BIT_ENABLE = 0;
   localparam int BIT_LAUNCH = 1;
   localparam int BIT_DONE = 2;
   localparam int BIT_BUSY = 8;
   // learn config fields
   localparam int POS_BASE = 0;
   localparam int POS_INC = 5;
   localparam int POS_HALFCYC = 7;
   // reset values
   localparam logic [7:0] RST_FLOOR = 8'h20;
   localparam logic [7:0] RST_CEILING = 8'hFF;
   localparam logic [7:0] RST_UPPER = 8'h40;
   localparam logic [7:0] RST_LOWER = 8'h20;
   // first level is base times 8
   localparam int LEVEL_SHIFT = 3;
   // half-cycles per hold code step
   localparam int HALFCYC_UNIT_SHIFT = 3;
   localparam int FILTER_SHIFT = 3;

   typedef enum logic [1:0] {
      LAC_IDLE = 2'b00,
      LAC_LOW = 2'b01,
      LAC_HIGH = 2'b11
   } lac_learn_t;

   typedef struct packed {
      logic enable;
      logic launch;
      logic done;
      logic [4:0] base;
      logic [1:0] inc;
      logic [1:0] hc_sel;
      logic [PWR_W-1:0] res_lo;
      logic [PWR_W-1:0] res_hi;
      logic [CUR_W-1:0] floor_lvl;
      logic [CUR_W-1:0] ceil_lvl;
      logic [7:0] upper;
      logic [7:0] lower;
      lac_learn_t st;
      logic [5:0] hc_cnt;
      logic [CUR_W-1:0] cur;
      logic [PWR_W-1:0] load;
      logic [DATA_W-1:0] rdata;
   } lac_state_t;
endpackage : lac_pkg

// ### rtl/lac_if.sv
// Purpose: carries loss model and power filter signals inside the block
// Assumes: one clock domain
// Notes: driven by the top, read by the two helpers, which drive loss and power back
`timescale 1ns/100ps
interface lac_if (
   input wire logic clk,
   input wire logic reset_n
);
   logic [10:0] res_lo;
   logic [10:0] res_hi;
   logic [7:0] level1;
   logic [1:0] inc_code;
   logic [7:0] cur;
   logic [10:0] loss;
   logic [10:0] sample;
   logic sample_valid;
   logic [10:0] power;
   modport top (output res_lo, res_hi, level1, inc_code, cur, sample, sample_valid, input loss, power);
   modport interp (input clk, reset_n, res_lo, res_hi, level1, inc_code, cur, output loss);
   modport meter (input clk, reset_n, sample, sample_valid, output power);
endinterface : lac_if

// ### rtl/lac_loss_interp.sv
// Purpose: constant loss at the present coil current from two learned points
// Assumes: the level spacing is a power of two, so division is a shift
// Notes: result registered, one cycle behind the current
`timescale 1ns/100ps
module lac_loss_interp (
   lac_if.interp bus
);
   typedef struct packed {
      logic [10:0] loss;
   } lac_interp_state_t;

   lac_interp_state_t r_reg;
   lac_interp_state_t r_next;
   logic signed [11:0] diff;
   logic signed [8:0] offs;
   logic signed [20:0] prod;
   logic signed [20:0] sum;
   logic [2:0] sh;

   always_comb begin
      case (bus.inc_code)
         2'b00: sh = 3'd7;
         2'b01: sh = 3'd4;
         2'b10: sh = 3'd5;
         default: sh = 3'd6;
      endcase
      diff = $signed({1'b0, bus.res_hi}) - $signed({1'b0, bus.res_lo});
      offs = $signed({1'b0, bus.cur}) - $signed({1'b0, bus.level1});
      prod = diff * offs;
      // straight line through both points, extended past them too
      sum = $signed({10'h000, bus.res_lo}) + (prod >>> sh);
      r_next = r_reg;
      if (sum < 0) begin
         r_next.loss = 11'h000;
      end else if (sum > 21'sh007FF) begin
         r_next.loss = 11'h7FF;
      end else begin
         r_next.loss = sum[10:0];
      end
   end

   always_ff @(posedge bus.clk or negedge bus.reset_n) begin
      if (!bus.reset_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign bus.loss = r_reg.loss;
endmodule : lac_loss_interp

// ### rtl/lac_power_filter.sv
// Purpose: smooths supply power samples
// Assumes: samples come on the block clock with a valid strobe
// Notes: first-order low pass, keeps fraction bits to avoid a dead band
`timescale 1ns/100ps
module lac_power_filter #(
   parameter int SHIFT = lac_pkg::FILTER_SHIFT
) (
   lac_if.meter bus
);
   if (SHIFT < 1 || SHIFT > 6) begin : g_chk
      $error("lac_power_filter: SHIFT must be 1 to 6");
   end

   typedef struct packed {
      logic [10+SHIFT:0] acc;
   } lac_filter_state_t;

   lac_filter_state_t r_reg;
   lac_filter_state_t r_next;

   always_comb begin
      r_next = r_reg;
      if (bus.sample_valid) begin
         r_next.acc = r_reg.acc + {{SHIFT{1'b0}}, bus.sample} - {{SHIFT{1'b0}}, r_reg.acc[10+SHIFT:SHIFT]};
      end
   end

   always_ff @(posedge bus.clk or negedge bus.reset_n) begin
      if (!bus.reset_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign bus.power = r_reg.acc[10+SHIFT:SHIFT];
endmodule : lac_power_filter

// ### rtl/lac_core.sv
// Purpose: load adaptive coil current control with no-load loss learning
// Assumes: power samples and half-cycle pulses come on i_clk
// Notes: registers on a plain port, read data one cycle after the strobe
`timescale 1ns/100ps
module lac_core (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [lac_pkg::ADDR_W-1:0] i_addr,
   input wire logic [lac_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [lac_pkg::DATA_W-1:0] o_rdata,
   input wire logic [lac_pkg::PWR_W-1:0] i_supply_power,
   input wire logic i_power_valid,
   input wire logic i_halfcycle,
   output logic [lac_pkg::CUR_W-1:0] o_current_value,
   output logic [lac_pkg::PWR_W-1:0] o_load_power,
   output logic o_learning
);
   lac_pkg::lac_state_t r_reg;
   lac_pkg::lac_state_t r_next;
   logic [7:0] level1;
   logic [8:0] level2_sum;
   logic [7:0] level2;
   logic [7:0] inc_val;
   logic [5:0] hc_target;
   logic [5:0] hc_inc;
   logic [10:0] loss;
   logic [10:0] power;
   logic [10:0] load_now;
   logic hold_done;

   lac_if link (
      .clk(i_clk),
      .reset_n(i_reset_n)
   );

   lac_loss_interp u_interp (
      .bus(link.interp)
   );

   lac_power_filter #(
      .SHIFT(lac_pkg::FILTER_SHIFT)
   ) u_filter (
      .bus(link.meter)
   );

   assign link.res_lo = r_reg.res_lo;
   assign link.res_hi = r_reg.res_hi;
   assign link.level1 = level1;
   assign link.inc_code = r_reg.inc;
   assign link.cur = r_reg.cur;
   assign link.sample = i_supply_power;
   assign link.sample_valid = i_power_valid;
   assign loss = link.loss;
   assign power = link.power;

   always_comb begin
      level1 = {r_reg.base, 3'b000};
      case (r_reg.inc)
         2'b00: inc_val = 8'h80;
         2'b01: inc_val = 8'h10;
         2'b10: inc_val = 8'h20;
         default: inc_val = 8'h40;
      endcase
      level2_sum = {1'b0, level1} + {1'b0, inc_val};
      // software should keep the second level within range; saturate if not
      level2 = level2_sum[8] ? 8'hFF : level2_sum[7:0];
      hc_target = {({1'b0, r_reg.hc_sel} + 3'h1), 3'b000};
      hc_inc = r_reg.hc_cnt + 6'h01;
      hold_done = i_halfcycle && (hc_inc == hc_target);
      // losses above the measured power mean no load at all
      load_now = (power > loss) ? (power - loss) : 11'h000;
   end

   always_comb begin
      r_next = r_reg;
      r_next.rdata = '0;
      r_next.load = load_now;

      if (i_wr) begin
         case (i_addr)
            lac_pkg::OFS_CTRL: begin
               r_next.enable = i_wdata[lac_pkg::BIT_ENABLE];
               // launch only from rest and only with control on
               if (i_wdata[lac_pkg::BIT_LAUNCH] && i_wdata[lac_pkg::BIT_ENABLE] &&
                   r_reg.st == lac_pkg::LAC_IDLE) begin
                  r_next.launch = 1'b1;
                  r_next.done = 1'b0;
                  r_next.st = lac_pkg::LAC_LOW;
                  r_next.hc_cnt = 6'h00;
               end
            end
            lac_pkg::OFS_LEARN_CFG: begin
               if (r_reg.st == lac_pkg::LAC_IDLE) begin
                  r_next.base = i_wdata[lac_pkg::POS_BASE +: 5];
                  r_next.inc = i_wdata[lac_pkg::POS_INC +: 2];
                  r_next.hc_sel = i_wdata[lac_pkg::POS_HALFCYC +: 2];
               end
            end
            lac_pkg::OFS_RESULT_LOW: begin
               r_next.res_lo = i_wdata[10:0];
            end
            lac_pkg::OFS_RESULT_HIGH: begin
               r_next.res_hi = i_wdata[10:0];
            end
            lac_pkg::OFS_LIMITS: begin
               r_next.floor_lvl = i_wdata[7:0];
               r_next.ceil_lvl = i_wdata[15:8];
            end
            lac_pkg::OFS_BAND: begin
               r_next.upper = i_wdata[7:0];
               r_next.lower = i_wdata[15:8];
            end
            default: begin
            end
         endcase
      end

      case (r_reg.st)
         lac_pkg::LAC_IDLE: begin
            if (r_reg.enable) begin
               if (load_now > {3'b000, r_reg.upper}) begin
                  // jump straight to ceiling so no step is lost
                  r_next.cur = r_reg.ceil_lvl;
               end else if (i_halfcycle && load_now < {3'b000, r_reg.lower} &&
                            r_reg.cur > r_reg.floor_lvl) begin
                  r_next.cur = r_reg.cur - 8'h01;
               end
            end else begin
               r_next.cur = r_reg.ceil_lvl;
            end
         end
         lac_pkg::LAC_LOW: begin
            r_next.cur = level1;
            if (i_halfcycle) begin
               r_next.hc_cnt = hc_inc;
            end
            if (hold_done) begin
               r_next.res_lo = power;
               r_next.st = lac_pkg::LAC_HIGH;
               r_next.cur = level2;
               r_next.hc_cnt = 6'h00;
            end
         end
         lac_pkg::LAC_HIGH: begin
            r_next.cur = level2;
            if (i_halfcycle) begin
               r_next.hc_cnt = hc_inc;
            end
            if (hold_done) begin
               r_next.res_hi = power;
               r_next.st = lac_pkg::LAC_IDLE;
               r_next.launch = 1'b0;
               r_next.done = 1'b1;
               r_next.cur = r_reg.ceil_lvl;
               r_next.hc_cnt = 6'h00;
            end
         end
         default: begin
            r_next.st = lac_pkg::LAC_IDLE;
         end
      endcase

      // launch edge: first level applies at once, not one cycle late
      if (r_reg.st == lac_pkg::LAC_IDLE && r_next.st == lac_pkg::LAC_LOW) begin
         r_next.cur = level1;
      end

      // dropping enable abandons a run without marking it complete
      if (!r_next.enable && r_next.st != lac_pkg::LAC_IDLE) begin
         r_next.st = lac_pkg::LAC_IDLE;
         r_next.launch = 1'b0;
         r_next.hc_cnt = 6'h00;
         r_next.cur = r_next.ceil_lvl;
      end

      if (r_next.st == lac_pkg::LAC_IDLE && r_next.enable) begin
         if (r_next.cur > r_next.ceil_lvl) begin
            r_next.cur = r_next.ceil_lvl;
         end else if (r_next.cur < r_next.floor_lvl) begin
            r_next.cur = r_next.floor_lvl;
         end
      end

      if (i_rd) begin
         case (i_addr)
            lac_pkg::OFS_CTRL: begin
               r_next.rdata[lac_pkg::BIT_ENABLE] = r_reg.enable;
               r_next.rdata[lac_pkg::BIT_LAUNCH] = r_reg.launch;
               r_next.rdata[lac_pkg::BIT_DONE] = r_reg.done;
            end
            lac_pkg::OFS_LEARN_CFG: begin
               r_next.rdata[lac_pkg::POS_BASE +: 5] = r_reg.base;
               r_next.rdata[lac_pkg::POS_INC +: 2] = r_reg.inc;
               r_next.rdata[lac_pkg::POS_HALFCYC +: 2] = r_reg.hc_sel;
            end
            lac_pkg::OFS_RESULT_LOW: begin
               r_next.rdata[10:0] = r_reg.res_lo;
            end
            lac_pkg::OFS_RESULT_HIGH: begin
               r_next.rdata[10:0] = r_reg.res_hi;
            end
            lac_pkg::OFS_LIMITS: begin
               r_next.rdata = {r_reg.ceil_lvl, r_reg.floor_lvl};
            end
            lac_pkg::OFS_BAND: begin
               r_next.rdata = {r_reg.lower, r_reg.upper};
            end
            lac_pkg::OFS_STATUS: begin
               r_next.rdata[7:0] = r_reg.cur;
               r_next.rdata[lac_pkg::BIT_BUSY] = (r_reg.st != lac_pkg::LAC_IDLE);
            end
            lac_pkg::OFS_LOAD: begin
               r_next.rdata[10:0] = r_reg.load;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r_reg <= '0;
         r_reg.floor_lvl <= lac_pkg::RST_FLOOR;
         r_reg.ceil_lvl <= lac_pkg::RST_CEILING;
         r_reg.upper <= lac_pkg::RST_UPPER;
         r_reg.lower <= lac_pkg::RST_LOWER;
         r_reg.cur <= lac_pkg::RST_CEILING;
         r_reg.st <= lac_pkg::LAC_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_rdata = r_reg.rdata;
   assign o_current_value = r_reg.cur;
   assign o_load_power = r_reg.load;
   assign o_learning = (r_reg.st != lac_pkg::LAC_IDLE);
endmodule : lac_core

// ### verification/lac_core_monitor.sv
// Purpose: port-level checks of the load adaptive coil current block
// Assumes: one clock domain, async active-low reset
// Notes: sees only top-level ports, attached by bind from the bench
`timescale 1ns/100ps
module lac_core_monitor (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [lac_pkg::ADDR_W-1:0] i_addr,
   input wire logic [lac_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [lac_pkg::DATA_W-1:0] o_rdata,
   input wire logic [lac_pkg::PWR_W-1:0] i_supply_power,
   input wire logic i_power_valid,
   input wire logic i_halfcycle,
   input wire logic [lac_pkg::CUR_W-1:0] o_current_value,
   input wire logic [lac_pkg::PWR_W-1:0] o_load_power,
   input wire logic o_learning
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   logic ctrl_wr;
   assign ctrl_wr = i_wr && (i_addr == lac_pkg::OFS_CTRL);

   rdata_quiet_a: assert property (!i_rd |=> o_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   status_read_a: assert property (i_rd && i_addr == lac_pkg::OFS_STATUS |=>
      o_rdata == {7'h00, $past(o_learning), $past(o_current_value)}) else $error("status read wrong");
   load_read_a: assert property (i_rd && i_addr == lac_pkg::OFS_LOAD |=>
      o_rdata == {5'h00, $past(o_load_power)}) else $error("load power read wrong");
   launch_takes_a: assert property (ctrl_wr && i_wdata[1:0] == 2'b11 && !o_learning |=> o_learning)
      else $error("launch not taken");
   enable_gate_a: assert property (ctrl_wr && !i_wdata[0] |=> !o_learning)
      else $error("learning without enable");
   learn_hold_a: assert property (o_learning && !i_halfcycle && !ctrl_wr |=> o_learning)
      else $error("learning ended without a half-cycle");
   level_hold_a: assert property (o_learning && !i_halfcycle && !i_wr |=> $stable(o_current_value))
      else $error("learning level moved without a half-cycle");
   no_drop_a: assert property (!o_learning && !i_wr && !i_halfcycle |=>
      o_current_value >= $past(o_current_value)) else $error("current lowered without a half-cycle");
   step_one_a: assert property (!o_learning && !i_wr |=>
      {1'b0, o_current_value} + 9'h001 >= {1'b0, $past(o_current_value)}) else $error("current fell by more than one");

   cover property (ctrl_wr && i_wdata[1:0] == 2'b11);
   cover property ($fell(o_learning));
   cover property (!o_learning && i_halfcycle ##1 $changed(o_current_value));
endmodule : lac_core_monitor

// ### verification/lac_motor_model.sv
// Purpose: motor and supply seen from the block: power samples and half-cycles
// Assumes: power is four per current unit plus eight per load unit
// Notes: sample lines carry junk whenever the strobe is low
`timescale 1ns/100ps
module lac_motor_model #(
   parameter int HC_PERIOD = 40
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_current,
   input wire logic [7:0] i_load,
   output logic [10:0] o_power,
   output logic o_valid,
   output logic o_halfcycle
);
   logic [7:0] cnt_reg;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_reg <= 8'h00;
         o_power <= 11'h000;
         o_valid <= 1'b0;
         o_halfcycle <= 1'b0;
      end else begin
         cnt_reg <= (cnt_reg == 8'(HC_PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
         o_halfcycle <= (cnt_reg == 8'(HC_PERIOD - 1));
         o_valid <= ~o_valid;
         // loss rises with current, load adds on top
         o_power <= o_valid ? ~o_power : {1'b0, i_current, 2'b00} + {i_load, 3'b000};
      end
   end
endmodule : lac_motor_model

// ### verification/lac_core_bench.sv
// Purpose: self-checking bench for the load adaptive coil current block
// Assumes: motor model answers with power that tracks the applied current
// Notes: results are exact because the filter settles within each hold
`timescale 1ns/100ps
module lac_core_bench;
   logic i_clk, i_reset_n, i_wr, i_rd, i_power_valid, i_halfcycle, o_learning;
   logic [3:0] i_addr, a;
   logic [15:0] i_wdata, o_rdata, rv, keep, d;
   logic [10:0] i_supply_power, o_load_power;
   logic [7:0] o_current_value, l1, l2, fl, load_lvl;
   logic [4:0] base;
   logic [7:0] inc_tab [4] = '{8'h80, 8'h10, 8'h20, 8'h40};
   int mismatches, n_tests, cycles, n, w;

   lac_core dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_supply_power(i_supply_power), .i_power_valid(i_power_valid),
      .i_halfcycle(i_halfcycle), .o_current_value(o_current_value), .o_load_power(o_load_power),
      .o_learning(o_learning));
   lac_motor_model #(.HC_PERIOD(40)) motor (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_current(o_current_value),
      .i_load(load_lvl), .o_power(i_supply_power), .o_valid(i_power_valid), .o_halfcycle(i_halfcycle));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         close_out();
      end
   end

   function automatic logic [10:0] pw(input logic [7:0] c, input logic [7:0] l);
      return {1'b0, c, 2'b00} + {l, 3'b000};
   endfunction : pw
   task close_out;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task wr(input logic [3:0] wa, input logic [15:0] wd);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= wa;
      i_wdata <= wd;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] ra);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= ra;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 rv = o_rdata;
   endtask : rd
   // counts pulses as the design samples them, returns on the edge of the last
   task wait_hc(input int cnt);
      repeat (cnt) begin
         @(posedge i_clk);
         while (i_halfcycle !== 1'b1) @(posedge i_clk);
      end
   endtask : wait_hc

   initial begin
      void'($urandom(36));
      i_reset_n = 1'b0;
      {i_wr, i_rd, i_addr, i_wdata, load_lvl} = '0;
      {mismatches, n_tests, cycles} = '0;
      repeat (8) @(posedge i_clk);
      i_reset_n <= 1'b1;
      #1 chk("current after reset", {8'h00, o_current_value}, 16'h00FF);
      rd(lac_pkg::OFS_LIMITS);
      chk("limits", rv, {lac_pkg::RST_CEILING, lac_pkg::RST_FLOOR});
      a = 4'(8 + $urandom % 8);
      wr(a, 16'($urandom));
      rd(a);
      chk("unmapped", rv, 16'h0000);
      rd(lac_pkg::OFS_BAND);
      chk("band reset", rv, {lac_pkg::RST_LOWER, lac_pkg::RST_UPPER});
      d = 16'($urandom);
      wr(lac_pkg::OFS_BAND, d);
      rd(lac_pkg::OFS_BAND);
      chk("band written", rv, d);
      wr(lac_pkg::OFS_BAND, {lac_pkg::RST_LOWER, lac_pkg::RST_UPPER});
      wr(lac_pkg::OFS_CTRL, 16'h0002);
      #1 chk("launch without enable", {15'h0000, o_learning}, 16'h0000);
      $display("reset and enable test done");
      for (int k = 0; k < 4; k++) begin
         base = 5'(4 + $urandom % 12);
         l1 = {base, 3'b000};
         l2 = l1 + inc_tab[k];
         n = 8 * (4 - k);
         wr(lac_pkg::OFS_LEARN_CFG, 16'({2'(3 - k), 2'(k), base}));
         wr(lac_pkg::OFS_CTRL, 16'h0003);
         #1 chk("first level", {7'h00, o_learning, o_current_value}, {8'h01, l1});
         wait_hc(n);
         #1 chk("second level", {8'h00, o_current_value}, {8'h00, l2});
         wait_hc(n);
         #1 chk("after learning", {7'h00, o_learning, o_current_value}, 16'h00FF);
         rd(lac_pkg::OFS_CTRL);
         chk("ctrl done", rv, 16'h0005);
         rd(lac_pkg::OFS_RESULT_LOW);
         chk("result low", rv, {5'h00, pw(l1, 8'h00)});
         rd(lac_pkg::OFS_RESULT_HIGH);
         chk("result high", rv, {5'h00, pw(l2, 8'h00)});
         rd(lac_pkg::OFS_LEARN_CFG);
         chk("learn config", rv, 16'({2'(3 - k), 2'(k), base}));
         $display("learning test code %0d done", k);
      end
      fl = 8'(8'h40 + $urandom % 16);
      wr(lac_pkg::OFS_LIMITS, {8'hF0, fl});
      wait_hc(200);
      #1 chk("floor reached", {8'h00, o_current_value}, {8'h00, fl});
      rd(lac_pkg::OFS_STATUS);
      chk("status", rv, {8'h00, fl});
      rd(lac_pkg::OFS_LOAD);
      chk("no load power", rv, 16'h0000);
      @(posedge i_clk);
      load_lvl <= 8'(20 + $urandom % 20);
      for (w = 0; w < 40 && o_current_value !== 8'hF0; w++) @(posedge i_clk);
      #1 chk("raised at once", {8'h00, o_current_value}, 16'h00F0);
      repeat (400) @(posedge i_clk);
      rd(lac_pkg::OFS_LOAD);
      chk("load power", rv, {5'h00, pw(8'h00, load_lvl)});
      $display("regulation test done");
      @(posedge i_clk);
      load_lvl <= 8'h00;
      rd(lac_pkg::OFS_RESULT_LOW);
      keep = rv;
      wr(lac_pkg::OFS_CTRL, 16'h0003);
      wr(lac_pkg::OFS_CTRL, 16'h0000);
      #1 chk("abort", {7'h00, o_learning, o_current_value}, 16'h00F0);
      rd(lac_pkg::OFS_CTRL);
      chk("ctrl after abort", rv, 16'h0000);
      rd(lac_pkg::OFS_RESULT_LOW);
      chk("result kept", rv, keep);
      d = 16'($urandom % 2048);
      wr(lac_pkg::OFS_RESULT_HIGH, d);
      rd(lac_pkg::OFS_RESULT_HIGH);
      chk("result written", rv, d);
      $display("abort test done");
      close_out();
   end
endmodule : lac_core_bench

bind lac_core lac_core_monitor mon (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_supply_power(i_supply_power), .i_power_valid(i_power_valid),
   .i_halfcycle(i_halfcycle), .o_current_value(o_current_value), .o_load_power(o_load_power),
   .o_learning(o_learning));
